// ===== hdl/plsm_regs.svh
/*
 * Register map, field positions, reset values and timing constants of the
 * port logout and session manager. Assumes inclusion by bare name.
 */
`ifndef PLSM_REGS_SVH
`define PLSM_REGS_SVH

// Register byte addresses
`define PLSM_ADDR_CTRL 12'h000
`define PLSM_ADDR_STATUS 12'h004
`define PLSM_ADDR_LOGOUT_RX 12'h008
`define PLSM_ADDR_HOLD 12'h00c
`define PLSM_ADDR_SESSION 12'h010
`define PLSM_ADDR_NEXUS 12'h014
`define PLSM_ADDR_EVENT 12'h018
`define PLSM_ADDR_LOGOUT_TX 12'h01c

// Control register fields
`define PLSM_CTRL_NETWORK 0
`define PLSM_CTRL_IS_DRIVE 1
`define PLSM_CTRL_RESET 32'h0000_0002

// Control event pulses (write one to strobe)
`define PLSM_EV_TX_LOGIN 0
`define PLSM_EV_RX_LOGIN 1
`define PLSM_EV_CONNECT_REQ 2
`define PLSM_EV_CONNECT_RX 3
`define PLSM_EV_IMPLICIT 4
`define PLSM_EV_EXT_TRIGGER 5
`define PLSM_EV_SEND_LOGOUT 6
`define PLSM_EV_NEW_CONN_DRIVE 7

// Logout payload layout
`define PLSM_PL_HOLD_MSB 31
`define PLSM_PL_HOLD_LSB 16
`define PLSM_PL_TRIG_BIT 15
`define PLSM_PL_CAUSE_MSB 14
`define PLSM_PL_CAUSE_LSB 8
`define PLSM_HOLD_W 16

// Timebase: 250 MHz clock, one second tick
`define PLSM_CLK_MHZ 250
`define PLSM_SECOND_US 1000000
`define PLSM_TICK_CYCLES (`PLSM_CLK_MHZ * `PLSM_SECOND_US)

`endif

// ===== hdl/plsm_pkg.sv
/*
 * Types of the port logout and session manager.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package plsm_pkg;
    typedef enum logic [2:0] {
        PLSM_ST_INITIAL,
        PLSM_ST_ACTIVE,
        PLSM_ST_LOGOUT_WAIT,
        PLSM_ST_LOGGED_OUT
    } plsm_port_e;
endpackage

// ===== hdl/plsm_tick.sv
/*
 * One-second tick generator.
 * Assumes a synchronous active-low reset copy from the top module.
 */
`timescale 1ns/1ns
`include "plsm_regs.svh"
module plsm_tick #(
    parameter int TICK_CYCLES = `PLSM_TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_tick
);
    logic [31:0] count;

    // ====================================================================
    // Counter
    // Free-running so hold timing stays coarse-grained to one second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= 32'h0;
            o_tick <= 1'b0;
        end else if (count == 32'(TICK_CYCLES - 1)) begin
            count <= 32'h0;
            o_tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            o_tick <= 1'b0;
        end
    end
endmodule // plsm_tick

// ===== hdl/plsm_hold_timer.sv
/*
 * Logout hold timer counting seconds.
 * Assumes a one-cycle tick input each second.
 */
`timescale 1ns/1ns
`include "plsm_regs.svh"
module plsm_hold_timer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [`PLSM_HOLD_W-1:0] i_value,
    input wire logic i_run,
    input wire logic i_tick,
    output logic [`PLSM_HOLD_W-1:0] o_remain,
    output logic o_expire
);
    logic armed;

    // ====================================================================
    // Countdown while logged out; a zero load leaves it unarmed (infinite)
    // Stays armed between logout receipt and our ack, so no load is lost
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_remain <= '0;
            armed <= 1'b0;
            o_expire <= 1'b0;
        end else begin
            o_expire <= 1'b0;
            if (i_load) begin
                o_remain <= i_value; // RULE_04
                armed <= (i_value != '0); // RULE_05
            end else if (armed && i_run && i_tick) begin
                o_remain <= o_remain - 16'h1; // RULE_20
                if (o_remain == 16'h1) begin
                    armed <= 1'b0;
                    o_expire <= 1'b1; // RULE_20
                end
            end
        end
    end
endmodule // plsm_hold_timer

// ===== hdl/plsm_top.sv
/*
 * Port logout and session manager for a drive or automation side port: logout handling,
 * session start and end, redundant connection resolution, nexus mapping.
 * Assumes an AHB-Lite master with single word transfers, one clock.
 */
//
// Functional notes
// RULE_01: Awaiting logout ack, drop non-ack frames
// RULE_02: Drive logout receipt: abort, events off, no login
// RULE_03: Automation side lacks event disable step
// RULE_04: Hold seconds from payload bytes 0-1
// RULE_05: Zero hold means stay logged out
// RULE_06: Byte 2: trigger bit, cause; byte 3 reserved
// RULE_07: After ack sent: defaults, logged out, close
// RULE_08: Ack received: defaults, initial state, close
// RULE_09: Drive should log in before hold expires; code keeps O_LOGIN_ALLOWED low until expiry, a received login or an ack
// RULE_10: Serial session starts on login transfer
// RULE_11: Network session starts on connect events
// RULE_12: Session ends on logout, ack, implicit logout
// RULE_13: Login seen: new connection replaces session
// RULE_14: No login: close drive-initiated connection
// RULE_15: Session keyed by port pair or addresses
// RULE_16: Fast status units go to session peer
// RULE_17: Nexus selects session, originator flag, unit
// RULE_18: Exchange tag serves as task tag
// RULE_19: Originator flag: automation 0, drive 1
// RULE_20: Hold timer counts seconds, signals expiry
`timescale 1ns/1ns
`include "plsm_regs.svh"
module plsm_top #(
    parameter int TICK_CYCLES = `PLSM_TICK_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_HSEL,
    input wire logic [11:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_RX_FRAME_VALID,
    input wire logic I_RX_FRAME_IS_ACK,
    input wire logic I_RX_FRAME_IS_LOGOUT,
    input wire logic I_LOGOUT_ACK_SENT,
    input wire logic [31:0] I_RX_PAYLOAD,
    input wire logic [31:0] I_PEER_ID,
    input wire logic [7:0] I_UNIT,
    input wire logic [15:0] I_TASK_TAG,
    output logic O_RX_FRAME_ACCEPT,
    output logic O_ABORT_EXCHANGES,
    output logic O_ASYNC_EVENT_REPORTING,
    output logic O_LOGIN_ALLOWED,
    output logic O_RESTORE_DEFAULTS,
    output logic O_CLOSE_CONNECTION,
    output logic O_SEND_LOGOUT,
    output logic O_SESSION_ACTIVE,
    output logic [31:0] O_SESSION_PEER,
    output logic O_EXCHANGE_ORIGINATOR_FLAG,
    output logic [7:0] O_UNIT,
    output logic [15:0] O_EXCHANGE_TAG,
    output logic O_HOLD_EXPIRED
);
    logic rst_meta, rst_n;
    logic haddr_ph, hwrite_ph;
    logic [11:0] haddr_q;
    logic [31:0] ctrl, logout_rx, logout_tx;
    logic [7:0] ev;
    logic login_seen, need_trigger;
    logic [6:0] logout_cause;
    plsm_pkg::plsm_port_e port_st;
    logic tick, hold_expire;
    logic [`PLSM_HOLD_W-1:0] hold_remain;
    logic hold_load;
    logic rx_logout, rx_ack, session_start, session_end, replace_conn;

    // ====================================================================
    // Reset release through two flops
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ====================================================================
    // AHB-Lite slave: zero wait states, always OKAY
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            haddr_ph <= 1'b0;
            hwrite_ph <= 1'b0;
            haddr_q <= 12'h0;
        end else if (I_HREADY) begin
            haddr_ph <= I_HSEL && I_HTRANS[1];
            hwrite_ph <= I_HWRITE;
            haddr_q <= I_HADDR;
        end
    end

    // Bus write side; event strobes last one cycle
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `PLSM_CTRL_RESET;
            logout_tx <= 32'h0;
            ev <= 8'h0;
        end else begin
            ev <= 8'h0;
            if (haddr_ph && hwrite_ph) begin
                case (haddr_q)
                    `PLSM_ADDR_CTRL: ctrl <= I_HWDATA;
                    `PLSM_ADDR_LOGOUT_TX: logout_tx <= I_HWDATA;
                    `PLSM_ADDR_EVENT: ev <= I_HWDATA[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_HRDATA <= 32'h0;
        end else if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
            case (I_HADDR)
                `PLSM_ADDR_CTRL: O_HRDATA <= ctrl;
                `PLSM_ADDR_STATUS: O_HRDATA <= {24'h0, need_trigger, login_seen,
                    O_SESSION_ACTIVE, O_HOLD_EXPIRED, 1'b0, 3'(port_st)};
                `PLSM_ADDR_LOGOUT_RX: O_HRDATA <= logout_rx;
                `PLSM_ADDR_HOLD: O_HRDATA <= {16'h0, hold_remain};
                `PLSM_ADDR_SESSION: O_HRDATA <= O_SESSION_PEER;
                `PLSM_ADDR_NEXUS: O_HRDATA <= {25'h0, logout_cause};
                `PLSM_ADDR_LOGOUT_TX: O_HRDATA <= logout_tx;
                default: O_HRDATA <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end
    end

    // ====================================================================
    // Frame classification
    assign rx_logout = I_RX_FRAME_VALID && I_RX_FRAME_IS_LOGOUT;
    assign rx_ack = I_RX_FRAME_VALID && I_RX_FRAME_IS_ACK &&
        (port_st == plsm_pkg::PLSM_ST_LOGOUT_WAIT);
    assign session_start = ctrl[`PLSM_CTRL_NETWORK] ?
        (ev[`PLSM_EV_CONNECT_REQ] || ev[`PLSM_EV_CONNECT_RX]) : // RULE_11
        (ev[`PLSM_EV_TX_LOGIN] || ev[`PLSM_EV_RX_LOGIN]); // RULE_10
    assign session_end = I_LOGOUT_ACK_SENT || rx_ack || ev[`PLSM_EV_IMPLICIT]; // RULE_12
    // Login seen plus a new network connection replaces the session
    assign replace_conn = ctrl[`PLSM_CTRL_NETWORK] && O_SESSION_ACTIVE && login_seen &&
        ev[`PLSM_EV_CONNECT_RX];
    assign hold_load = rx_logout && (port_st != plsm_pkg::PLSM_ST_LOGOUT_WAIT);

    // ====================================================================
    // Port state machine
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            port_st <= plsm_pkg::PLSM_ST_INITIAL;
        end else begin
            case (port_st)
                plsm_pkg::PLSM_ST_INITIAL, plsm_pkg::PLSM_ST_ACTIVE: begin
                    if (ev[`PLSM_EV_SEND_LOGOUT]) begin
                        port_st <= plsm_pkg::PLSM_ST_LOGOUT_WAIT;
                    end else if (I_LOGOUT_ACK_SENT) begin
                        port_st <= plsm_pkg::PLSM_ST_LOGGED_OUT; // RULE_07
                    end else if (session_start) begin
                        port_st <= plsm_pkg::PLSM_ST_ACTIVE;
                    end
                end
                plsm_pkg::PLSM_ST_LOGOUT_WAIT: begin
                    if (rx_ack) begin
                        port_st <= plsm_pkg::PLSM_ST_INITIAL; // RULE_08
                    end
                end
                plsm_pkg::PLSM_ST_LOGGED_OUT: begin
                    // Leave on login, or on expiry once any trigger is given
                    if (ev[`PLSM_EV_RX_LOGIN] ||
                        (hold_expire && !need_trigger) ||
                        (ev[`PLSM_EV_EXT_TRIGGER] && hold_remain == 16'h0 &&
                         logout_rx[`PLSM_PL_HOLD_MSB:`PLSM_PL_HOLD_LSB] != 16'h0)) begin
                        port_st <= plsm_pkg::PLSM_ST_INITIAL; // RULE_05
                    end
                end
                default: port_st <= plsm_pkg::PLSM_ST_INITIAL;
            endcase
        end
    end

    // ====================================================================
    // Logout payload capture
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            logout_rx <= 32'h0;
            need_trigger <= 1'b0;
            logout_cause <= 7'h0;
        end else if (hold_load) begin
            logout_rx <= I_RX_PAYLOAD; // RULE_04
            need_trigger <= I_RX_PAYLOAD[`PLSM_PL_TRIG_BIT]; // RULE_06
            logout_cause <= I_RX_PAYLOAD[`PLSM_PL_CAUSE_MSB:`PLSM_PL_CAUSE_LSB]; // RULE_06
        end else if (ev[`PLSM_EV_EXT_TRIGGER]) begin
            need_trigger <= 1'b0;
        end
    end

    plsm_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .o_tick(tick)
    );

    plsm_hold_timer u_hold (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_load(hold_load),
        .i_value(I_RX_PAYLOAD[`PLSM_PL_HOLD_MSB:`PLSM_PL_HOLD_LSB]),
        .i_run(port_st == plsm_pkg::PLSM_ST_LOGGED_OUT || I_LOGOUT_ACK_SENT),
        .i_tick(tick),
        .o_remain(hold_remain),
        .o_expire(hold_expire)
    );

    // ====================================================================
    // Logout side effects and frame filtering
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_RX_FRAME_ACCEPT <= 1'b0;
            O_ABORT_EXCHANGES <= 1'b0;
            O_ASYNC_EVENT_REPORTING <= 1'b0;
            O_LOGIN_ALLOWED <= 1'b1;
            O_RESTORE_DEFAULTS <= 1'b0;
            O_CLOSE_CONNECTION <= 1'b0;
            O_SEND_LOGOUT <= 1'b0;
            O_HOLD_EXPIRED <= 1'b0;
        end else begin
            // Only acks pass while our logout is outstanding
            O_RX_FRAME_ACCEPT <= I_RX_FRAME_VALID &&
                (port_st != plsm_pkg::PLSM_ST_LOGOUT_WAIT || I_RX_FRAME_IS_ACK); // RULE_01
            O_ABORT_EXCHANGES <= hold_load; // RULE_02
            O_SEND_LOGOUT <= ev[`PLSM_EV_SEND_LOGOUT];
            O_RESTORE_DEFAULTS <= I_LOGOUT_ACK_SENT || rx_ack; // RULE_07 RULE_08
            // Network variant closes on logout end, stale connections too
            O_CLOSE_CONNECTION <= ctrl[`PLSM_CTRL_NETWORK] &&
                (I_LOGOUT_ACK_SENT || rx_ack || replace_conn || // RULE_07 RULE_08 RULE_13
                 (O_SESSION_ACTIVE && !login_seen && ev[`PLSM_EV_NEW_CONN_DRIVE])); // RULE_14
            // Drive side event reporting is off after logout, on with login
            if (hold_load && ctrl[`PLSM_CTRL_IS_DRIVE]) begin
                O_ASYNC_EVENT_REPORTING <= 1'b0; // RULE_02
            end else if (ev[`PLSM_EV_RX_LOGIN] && ctrl[`PLSM_CTRL_IS_DRIVE]) begin
                O_ASYNC_EVENT_REPORTING <= 1'b1;
            end
            if (hold_load) begin
                O_LOGIN_ALLOWED <= 1'b0; // RULE_02 RULE_03
            end else if (hold_expire || ev[`PLSM_EV_RX_LOGIN] || rx_ack) begin
                O_LOGIN_ALLOWED <= 1'b1; // RULE_09
            end
            // Expiry flag is sticky until a new logout or login
            if (hold_expire) begin
                O_HOLD_EXPIRED <= 1'b1; // RULE_20
            end else if (hold_load || ev[`PLSM_EV_RX_LOGIN]) begin
                O_HOLD_EXPIRED <= 1'b0;
            end
        end
    end

    // ====================================================================
    // Session tracking, keyed by peer identity
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_SESSION_ACTIVE <= 1'b0;
            O_SESSION_PEER <= 32'h0;
            login_seen <= 1'b0;
        end else begin
            if (replace_conn) begin
                O_SESSION_ACTIVE <= 1'b1; // RULE_13
                O_SESSION_PEER <= I_PEER_ID;
                login_seen <= 1'b0;
            end else if (session_end || hold_load) begin
                O_SESSION_ACTIVE <= 1'b0; // RULE_12
                login_seen <= 1'b0;
            end else if (session_start && !O_SESSION_ACTIVE) begin
                O_SESSION_ACTIVE <= 1'b1;
                O_SESSION_PEER <= I_PEER_ID; // RULE_15 RULE_16
            end
            if (!replace_conn && !session_end && !hold_load && ev[`PLSM_EV_RX_LOGIN]) begin
                login_seen <= 1'b1;
            end
        end
    end

    // ====================================================================
    // Nexus to frame header mapping
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_EXCHANGE_ORIGINATOR_FLAG <= 1'b0;
            O_UNIT <= 8'h0;
            O_EXCHANGE_TAG <= 16'h0;
        end else begin
            O_EXCHANGE_ORIGINATOR_FLAG <= ctrl[`PLSM_CTRL_IS_DRIVE]; // RULE_17 RULE_19
            O_UNIT <= I_UNIT; // RULE_17
            O_EXCHANGE_TAG <= I_TASK_TAG; // RULE_18
        end
    end

    // ====================================================================
    // Checks
    AST_FILTER: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_01
        (I_RX_FRAME_VALID && !I_RX_FRAME_IS_ACK && port_st == plsm_pkg::PLSM_ST_LOGOUT_WAIT)
        |=> !O_RX_FRAME_ACCEPT) else $error("frame accepted during logout wait");
    AST_ABORT: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_02
        hold_load |=> O_ABORT_EXCHANGES && !O_LOGIN_ALLOWED) else $error("logout not handled");
    AST_AER: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_02
        (hold_load && ctrl[`PLSM_CTRL_IS_DRIVE]) |=> !O_ASYNC_EVENT_REPORTING)
        else $error("event reporting left on");
    AST_HOLD: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_04
        hold_load |=> hold_remain == $past(I_RX_PAYLOAD[`PLSM_PL_HOLD_MSB:`PLSM_PL_HOLD_LSB]))
        else $error("hold not loaded");
    AST_LOGGED_OUT: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_07
        (I_LOGOUT_ACK_SENT && port_st == plsm_pkg::PLSM_ST_ACTIVE && !ev[`PLSM_EV_SEND_LOGOUT])
        |=> port_st == plsm_pkg::PLSM_ST_LOGGED_OUT && O_RESTORE_DEFAULTS)
        else $error("no logged out entry");
    AST_INITIAL: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_08
        rx_ack |=> port_st == plsm_pkg::PLSM_ST_INITIAL && !O_SESSION_ACTIVE)
        else $error("no initial entry");
    AST_END: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_12
        (session_end && !replace_conn) |=> !O_SESSION_ACTIVE) else $error("session kept");
    AST_FLAG: assert property (@(posedge I_CLK) disable iff (!rst_n) // RULE_19
        $stable(ctrl) |=> O_EXCHANGE_ORIGINATOR_FLAG == $past(ctrl[`PLSM_CTRL_IS_DRIVE]))
        else $error("originator flag wrong");
endmodule // plsm_top

// ===== test/plsm_peer.sv
/*
 * Far-end port model: raises received frames and the ack-sent strobe.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ns
module plsm_peer (
    input wire logic i_clk,
    input wire logic i_send_logout,
    output logic o_valid,
    output logic o_is_ack,
    output logic o_is_logout,
    output logic o_ack_sent,
    output logic [31:0] o_payload
);
    logic held = 1'b0;
    // ==========================================
    // Idle levels
    initial begin
        o_valid = 1'b0;
        o_is_ack = 1'b0;
        o_is_logout = 1'b0;
        o_ack_sent = 1'b0;
        o_payload = 32'h5a5a_5a5a;
    end
    // Our logout is latched in held, which nothing here reads
    always @(posedge i_clk) begin
        if (i_send_logout) begin
            held <= 1'b1;
        end
    end
    // One frame for one cycle; qualifiers scrambled after it, not held
    task automatic frame(input logic ack, input logic lo, input logic [31:0] pl);
        o_valid <= 1'b1;
        o_is_ack <= ack;
        o_is_logout <= lo;
        o_payload <= pl;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_is_ack <= ~ack;
        o_is_logout <= ~lo;
        o_payload <= ~pl;
    endtask
    // Logout payload: hold seconds MSB first, trigger bit, cause, reserved
    task automatic logout(input logic [15:0] hs, input logic tr, input logic [6:0] c);
        frame(1'b0, 1'b1, {hs, tr, c, 8'h00});
    endtask
    // Local acknowledgement of a received logout went out
    task automatic ack_sent();
        o_ack_sent <= 1'b1;
        @(posedge i_clk);
        o_ack_sent <= 1'b0;
    endtask
endmodule // plsm_peer

// ===== test/plsm_test.sv
/*
 * Bench of the port logout and session manager: bus master, peer model,
 * read checker. Assumes a zero-wait bus slave and a 10-cycle second.
 */
`timescale 1ns/1ns
`include "plsm_regs.svh"
module plsm_test;
    localparam logic [11:0] A_ST = `PLSM_ADDR_STATUS;
    localparam logic [11:0] A_EV = `PLSM_ADDR_EVENT;
    logic I_CLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic [11:0] I_HADDR = 12'h000;
    logic [1:0] I_HTRANS = 2'b00;
    logic I_HWRITE = 1'b0;
    logic [31:0] I_HWDATA = 32'h0000_0000;
    logic [31:0] I_PEER_ID = 32'h0000_0000;
    logic [7:0] I_UNIT = 8'h00;
    logic [15:0] I_TASK_TAG = 16'h0000;
    logic [31:0] O_HRDATA, O_SESSION_PEER;
    logic O_HREADYOUT, O_HRESP, O_RX_FRAME_ACCEPT, O_ABORT_EXCHANGES, O_ASYNC_EVENT_REPORTING;
    logic O_LOGIN_ALLOWED, O_RESTORE_DEFAULTS, O_CLOSE_CONNECTION, O_SEND_LOGOUT;
    logic O_SESSION_ACTIVE, O_EXCHANGE_ORIGINATOR_FLAG, O_HOLD_EXPIRED;
    logic [7:0] O_UNIT;
    logic [15:0] O_EXCHANGE_TAG;
    logic valid, is_ack, is_lo, ack_sent;
    logic [31:0] pl, pid, v;
    logic [4:0] seen = 5'h00;
    logic clr = 1'b0, rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int failures = 0;
    int n_checks = 0;
    int seed = 32'h6b8f;
    int n;

    plsm_top #(.TICK_CYCLES(10)) i_plsm_top (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
        .I_HSEL(1'b1), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
        .I_HSIZE(3'b010), .I_HWDATA(I_HWDATA), .I_HREADY(O_HREADYOUT),
        .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
        .I_RX_FRAME_VALID(valid), .I_RX_FRAME_IS_ACK(is_ack), .I_RX_FRAME_IS_LOGOUT(is_lo),
        .I_LOGOUT_ACK_SENT(ack_sent), .I_RX_PAYLOAD(pl), .I_PEER_ID(I_PEER_ID),
        .I_UNIT(I_UNIT), .I_TASK_TAG(I_TASK_TAG), .O_RX_FRAME_ACCEPT(O_RX_FRAME_ACCEPT),
        .O_ABORT_EXCHANGES(O_ABORT_EXCHANGES),
        .O_ASYNC_EVENT_REPORTING(O_ASYNC_EVENT_REPORTING),
        .O_LOGIN_ALLOWED(O_LOGIN_ALLOWED), .O_RESTORE_DEFAULTS(O_RESTORE_DEFAULTS),
        .O_CLOSE_CONNECTION(O_CLOSE_CONNECTION), .O_SEND_LOGOUT(O_SEND_LOGOUT),
        .O_SESSION_ACTIVE(O_SESSION_ACTIVE), .O_SESSION_PEER(O_SESSION_PEER),
        .O_EXCHANGE_ORIGINATOR_FLAG(O_EXCHANGE_ORIGINATOR_FLAG), .O_UNIT(O_UNIT),
        .O_EXCHANGE_TAG(O_EXCHANGE_TAG), .O_HOLD_EXPIRED(O_HOLD_EXPIRED));
    plsm_peer i_plsm_peer (.i_clk(I_CLK), .i_send_logout(O_SEND_LOGOUT), .o_valid(valid),
        .o_is_ack(is_ack), .o_is_logout(is_lo), .o_ack_sent(ack_sent), .o_payload(pl));

    // ==========================================
    // Clock, pulse capture, read checker
    always #2 I_CLK = ~I_CLK;
    // Sticky capture, so a one-cycle pulse cannot slip between checks
    always @(posedge I_CLK) begin
        if (clr) begin
            seen <= 5'h00;
        end else begin
            seen <= seen | {O_SEND_LOGOUT, O_CLOSE_CONNECTION, O_RESTORE_DEFAULTS,
                            O_ABORT_EXCHANGES, O_RX_FRAME_ACCEPT};
        end
    end
    // Read data is compared at the edge that closes its data phase
    always @(posedge I_CLK) begin
        if (rd_pend && O_HREADYOUT === 1'b1) begin
            check("read data", O_HRDATA & msk_q.pop_front(), exp_q.pop_front());
            check("response", O_HRESP, 1'b0);
        end
    end

    // ==========================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] ex);
        n_checks++;
        if (got !== ex) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Bounded wait for hready; a hang ends the run
    task automatic hwait();
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_HREADYOUT !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            test_done();
        end
    endtask
    // One single word transfer; a read notes its masked expectation
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        I_HTRANS <= 2'b10;
        I_HADDR <= a;
        I_HWRITE <= w;
        hwait();
        I_HTRANS <= 2'b00;
        I_HWDATA <= d;
        if (!w) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
            rd_pend <= 1'b1;
        end
        hwait();
        rd_pend <= 1'b0;
    endtask
    task automatic ev(input int b);
        bus(1'b1, A_EV, 32'h1 << b, 32'h0);
        repeat (4) @(posedge I_CLK);
    endtask
    task automatic clear();
        clr <= 1'b1;
        @(posedge I_CLK);
        clr <= 1'b0;
    endtask
    task automatic do_reset();
        I_RESET_N <= 1'b0;
        repeat (2) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        repeat (3) @(posedge I_CLK);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        do_reset();
        bus(1'b0, `PLSM_ADDR_CTRL, `PLSM_CTRL_RESET, 32'hffff_ffff);
        bus(1'b0, 12'h0f0, 32'h0, 32'hffff_ffff);
        v = $random(seed);
        bus(1'b1, `PLSM_ADDR_LOGOUT_TX, v, 32'h0);
        bus(1'b0, `PLSM_ADDR_LOGOUT_TX, v, 32'hffff_ffff);
        // Serial session on a received login, drive side
        pid = $random(seed);
        I_PEER_ID <= pid;
        ev(`PLSM_EV_RX_LOGIN);
        check("session", {O_SESSION_ACTIVE, O_ASYNC_EVENT_REPORTING}, 2'b11);
        bus(1'b0, `PLSM_ADDR_SESSION, pid, 32'hffff_ffff);
        I_UNIT <= v[7:0];
        I_TASK_TAG <= v[23:8];
        repeat (3) @(posedge I_CLK);
        check("unit", O_UNIT, v[7:0]);
        check("tag", O_EXCHANGE_TAG, v[23:8]);
        check("flag drive", O_EXCHANGE_ORIGINATOR_FLAG, 1);
        bus(1'b1, `PLSM_ADDR_CTRL, 32'h0, 32'h0);
        repeat (3) @(posedge I_CLK);
        check("flag auto", O_EXCHANGE_ORIGINATOR_FLAG, 0);
        bus(1'b1, `PLSM_ADDR_CTRL, 32'h2, 32'h0);
        // Received logout, three seconds of hold
        clear();
        i_plsm_peer.logout(16'h0003, 1'b0, v[30:24]);
        repeat (3) @(posedge I_CLK);
        check("abort", seen, 5'b00011);
        check("events", O_ASYNC_EVENT_REPORTING, 0);
        check("login off", O_LOGIN_ALLOWED, 0);
        bus(1'b0, `PLSM_ADDR_LOGOUT_RX, {16'h0003, 1'b0, v[30:24], 8'h00}, 32'hffff_ff00);
        bus(1'b0, `PLSM_ADDR_NEXUS, {25'h0, v[30:24]}, 32'h7f);
        clear();
        i_plsm_peer.ack_sent();
        repeat (3) @(posedge I_CLK);
        check("after ack", seen, 5'b00100);
        bus(1'b0, A_ST, 32'h03, 32'h37);
        n = 0;
        while (O_HOLD_EXPIRED !== 1'b1 && n < 200) begin
            @(posedge I_CLK);
            n++;
        end
        check("hold span", 32'(n >= 10 && n < 200), 1);
        if (n >= 200) begin
            test_done();
        end
        check("login on", O_LOGIN_ALLOWED, 1);
        // Zero hold with trigger required: no expiry
        ev(`PLSM_EV_RX_LOGIN);
        i_plsm_peer.logout(16'h0000, 1'b1, 7'h11);
        i_plsm_peer.ack_sent();
        repeat (80) @(posedge I_CLK);
        check("no expiry", O_HOLD_EXPIRED, 0);
        bus(1'b0, A_ST, 32'h83, 32'h97);
        // Network port after a fresh reset
        do_reset();
        bus(1'b1, `PLSM_ADDR_CTRL, 32'h3, 32'h0);
        ev(`PLSM_EV_CONNECT_REQ);
        clear();
        ev(`PLSM_EV_NEW_CONN_DRIVE);
        check("drive conn", seen, 5'b01000);
        bus(1'b0, `PLSM_ADDR_SESSION, pid, 32'hffff_ffff);
        ev(`PLSM_EV_RX_LOGIN);
        v = $random(seed);
        I_PEER_ID <= v;
        clear();
        ev(`PLSM_EV_CONNECT_RX);
        check("replace", seen, 5'b01000);
        bus(1'b0, `PLSM_ADDR_SESSION, v, 32'hffff_ffff);
        clear();
        ev(`PLSM_EV_SEND_LOGOUT);
        check("send", seen, 5'b10000);
        bus(1'b0, A_ST, 32'h22, 32'h07);
        clear();
        i_plsm_peer.frame(1'b0, 1'b0, 32'h0);
        repeat (3) @(posedge I_CLK);
        check("dropped", seen, 5'b00000);
        i_plsm_peer.frame(1'b1, 1'b0, 32'h0);
        repeat (3) @(posedge I_CLK);
        check("ack rx", seen, 5'b01101);
        bus(1'b0, A_ST, 32'h00, 32'h27);
        ev(`PLSM_EV_CONNECT_REQ);
        ev(`PLSM_EV_IMPLICIT);
        check("implicit", O_SESSION_ACTIVE, 0);
        test_done();
    end
endmodule // plsm_test
